// File: verilog/xpc_regs.vh
// Purpose: constants for the crosspoint switch control port
// Assumes: one 100 MHz core clock, strobes sampled as pins
// Notes: codes are 4-bit routing codes per output
//
// What this block does
// - D3 high: address plus three-bit control code
// - D3 low: low bits pick input channel
// - write rising edge loads first rank; enable and latch codes act at once
// - latch rising edge copies all entries together
// - parallel routing or ground word changes exactly one entry
// - parallel codes route, ground, enable, latch
// - chip enables gate write; level latch option
// - serial shifts 32 bits; bad codes inhibit latch
// - power-up disables buffers, routing cleared to zero
`ifndef XPC_REGS_VH
`define XPC_REGS_VH
`define XPC_NUM_OUT 8
`define XPC_CODE_W 4
`define XPC_CHAIN_W 32
`define XPC_CODE_GND 4'h8
`define XPC_CODE_SER_ON 4'h9
`define XPC_CODE_SER_OFF 4'ha
`define XPC_CODE_ONE_OFF 4'hb
`define XPC_CODE_ONE_ON 4'hc
`define XPC_CODE_ALL_OFF 4'hd
`define XPC_CODE_ALL_ON 4'he
`define XPC_CODE_SW_LATCH 4'hf
`define XPC_CODE_RESET 4'h8
// idle pin levels: edge latch, strobes high, chip enabled
`define XPC_PIN_IDLE 13'h100e
`endif

// File: verilog/xpc_control_port.v
// Purpose: digital control port of an 8x8 crosspoint switch
// Assumes: write, latch and data pins are asynchronous to core_clk
// Notes: strobe edges are detected after two-flop synchronisers
`timescale 1ns/10ps
`include "xpc_regs.vh"
module xpc_control_port
(
    input wire core_clk,
    input wire rst_n,
    input wire interfaceModeSelect,
    input wire [2:0] outputBufferSelect,
    input wire [3:0] routingCodeLinesIn,
    input wire writeStrobe_n,
    input wire latchStrobe_n,
    input wire chipEnable,
    input wire chipEnable_n,
    input wire edgeLatchSelect,
    output reg serialDataOut,
    output reg [31:0] routeState,
    output reg [7:0] bufferEnable
);

// ----------------------------------------------------------------
// pin synchronisers
// ----------------------------------------------------------------
// latchStrobe_n is the latch line level: low = latch in level mode
// reset loads the idle pin levels, so release gives no false edge
reg [12:0] sync1_q;
reg [12:0] sync2_q;
wire [12:0] pinsIn;
assign pinsIn = {edgeLatchSelect, interfaceModeSelect, outputBufferSelect,
    routingCodeLinesIn, writeStrobe_n, latchStrobe_n, chipEnable,
    chipEnable_n};
always @(posedge core_clk or negedge rst_n)
begin
    if (!rst_n)
    begin
        sync1_q <= `XPC_PIN_IDLE;
        sync2_q <= `XPC_PIN_IDLE;
    end
    else
    begin
        sync1_q <= pinsIn;
        sync2_q <= sync1_q;
    end
end

// ----------------------------------------------------------------
// pin decode
// ----------------------------------------------------------------
wire edgeSel;
wire serMode;
wire [2:0] addr;
wire [3:0] code;
wire wrLvl;
wire latLvl;
wire chipSel;
assign edgeSel = sync2_q[12];
assign serMode = sync2_q[11];
assign addr = sync2_q[10:8];
assign code = sync2_q[7:4];
assign wrLvl = sync2_q[3];
assign latLvl = sync2_q[2];
assign chipSel = sync2_q[1] & ~sync2_q[0];

// ----------------------------------------------------------------
// strobe edges
// ----------------------------------------------------------------
reg wrPrev_q;
reg latPrev_q;
always @(posedge core_clk or negedge rst_n)
begin
    if (!rst_n)
    begin
        wrPrev_q <= 1'b1;
        latPrev_q <= 1'b1;
    end
    else
    begin
        wrPrev_q <= wrLvl;
        latPrev_q <= latLvl;
    end
end
// enables qualify the strobe edge: raising an enable while the
// strobe is high is not taken as a write
wire wrRise;
wire latRise;
assign wrRise = wrLvl & ~wrPrev_q & chipSel;
assign latRise = latLvl & ~latPrev_q;

// ----------------------------------------------------------------
// parallel word decode
// ----------------------------------------------------------------
reg swLatch;
reg wordLoad;
reg [7:0] enSet;
reg [7:0] enClr;
always @*
begin
    swLatch = 1'b0;
    wordLoad = 1'b0;
    enSet = 8'h00;
    enClr = 8'h00;
    if (wrRise && !serMode)
    begin
        case (code)
            `XPC_CODE_ONE_OFF:
            begin
                enClr[addr] = 1'b1;
            end
            `XPC_CODE_ONE_ON:
            begin
                enSet[addr] = 1'b1;
            end
            `XPC_CODE_ALL_OFF:
            begin
                enClr = 8'hff;
            end
            `XPC_CODE_ALL_ON:
            begin
                enSet = 8'hff;
            end
            `XPC_CODE_SW_LATCH:
            begin
                swLatch = latLvl;
            end
            // serial-only codes do nothing in parallel mode
            `XPC_CODE_SER_ON, `XPC_CODE_SER_OFF:
            begin
                wordLoad = 1'b0;
            end
            // routing and ground codes touch one entry only
            default:
            begin
                wordLoad = 1'b1;
            end
        endcase
    end
end

// ----------------------------------------------------------------
// first rank
// ----------------------------------------------------------------
reg [31:0] rank1_q;
reg [31:0] rank1_d;
integer i;
always @*
begin
    rank1_d = rank1_q;
    if (wrRise && serMode)
    begin
        rank1_d = {code[0], rank1_q[31:1]};
    end
    else if (wordLoad)
    begin
        for (i = 0; i < 8; i = i + 1)
        begin
            if (i == addr)
            begin
                rank1_d[i*4 +: 4] = code;
            end
        end
    end
end
always @(posedge core_clk or negedge rst_n)
begin
    if (!rst_n)
    begin
        rank1_q <= 32'h00000000;
    end
    else
    begin
        rank1_q <= rank1_d;
    end
end

// ----------------------------------------------------------------
// latch control
// ----------------------------------------------------------------
// serial codes above 1010 anywhere in the chain block latching
wire [7:0] badCode;
genvar g;
generate
    for (g = 0; g < 8; g = g + 1)
    begin : gChk
        assign badCode[g] = rank1_q[g*4+3] &
            (rank1_q[g*4 +: 3] > 3'h2);
    end
endgenerate
wire latchInhibit;
wire hwLatch;
wire doLatch;
assign latchInhibit = serMode & (|badCode);
assign hwLatch = edgeSel ? latRise : ~latLvl;
assign doLatch = (hwLatch | swLatch) & ~latchInhibit;

// ----------------------------------------------------------------
// buffer enables
// ----------------------------------------------------------------
// parallel enable codes act at once; serial ones wait for a latch
reg [7:0] bufEn_d;
integer k;
always @*
begin
    bufEn_d = (bufferEnable | enSet) & ~enClr;
    if (doLatch && serMode)
    begin
        for (k = 0; k < 8; k = k + 1)
        begin
            if (rank1_q[k*4 +: 4] == `XPC_CODE_SER_ON)
            begin
                bufEn_d[k] = 1'b1;
            end
            else if (rank1_q[k*4 +: 4] == `XPC_CODE_SER_OFF)
            begin
                bufEn_d[k] = 1'b0;
            end
        end
    end
end

// ----------------------------------------------------------------
// second rank and outputs
// ----------------------------------------------------------------
always @(posedge core_clk or negedge rst_n)
begin
    if (!rst_n)
    begin
        routeState <= 32'h00000000;
        bufferEnable <= 8'h00;
        serialDataOut <= 1'b0;
    end
    else
    begin
        serialDataOut <= rank1_q[0];
        bufferEnable <= bufEn_d;
        if (doLatch)
        begin
            routeState <= rank1_q;
        end
    end
end

endmodule // xpc_control_port

// File: dv/xpc_props.sv
// Purpose: port checks; Assumes: 5-clock levels; Notes: holds need 8 idle
`timescale 1ns/10ps
module xpc_props
(
    input wire core_clk,
    input wire rst_n,
    input wire interfaceModeSelect,
    input wire writeStrobe_n,
    input wire latchStrobe_n,
    input wire chipEnable,
    input wire serialDataOut,
    input wire [31:0] routeState,
    input wire [7:0] bufferEnable
);
default clocking @(posedge core_clk); endclocking
default disable iff (!rst_n);
pwr_off_a: assert property ($rose(rst_n) |-> bufferEnable == 8'h00)
    else $error("enables on");
pwr_route_a: assert property ($rose(rst_n) |-> routeState == 32'h0)
    else $error("route set");
rank_hold_a: assert property
    ((latchStrobe_n && writeStrobe_n)[*8] |-> $stable(routeState))
    else $error("route moved");
wr_quiet_a: assert property
    ($rose(writeStrobe_n) |-> ##1 $stable(routeState)[*2])
    else $error("early route");
ce_hold_a: assert property
    ((!chipEnable && latchStrobe_n)[*8] |-> $stable(bufferEnable))
    else $error("enable moved");
ce_shift_a: assert property
    ((!chipEnable && latchStrobe_n)[*8] |-> $stable(serialDataOut))
    else $error("shift moved");
ser_en_a: assert property
    ((interfaceModeSelect && latchStrobe_n)[*8] |-> $stable(bufferEnable))
    else $error("serial enable");
ser_out_a: assert property
    ((interfaceModeSelect && writeStrobe_n)[*8] |-> $stable(serialDataOut))
    else $error("serial out");
cover property ($rose(latchStrobe_n) && interfaceModeSelect);
cover property ($changed(bufferEnable));
cover property (!chipEnable && $rose(writeStrobe_n));
endmodule // xpc_props
bind xpc_control_port xpc_props chk_u (.*);

// File: dv/xpc_host.sv
// Purpose: host pin model; Assumes: core_clk; Notes: 5-clock levels
`timescale 1ns/10ps
module xpc_host
(
    input wire core_clk,
    output reg interfaceModeSelect = 1'h0,
    output reg [2:0] outputBufferSelect = 3'h0,
    output reg [3:0] routingCodeLinesIn = 4'h0,
    output reg writeStrobe_n = 1'h1,
    output reg latchStrobe_n = 1'h1,
    output reg chipEnable = 1'h1,
    output reg chipEnable_n = 1'h0
);
task w5;
    repeat (5) @(posedge core_clk);
endtask
task wr(input [2:0] a, input [3:0] c);
    outputBufferSelect <= a;
    routingCodeLinesIn <= c;
    w5;
    writeStrobe_n <= 1'h0;
    w5;
    writeStrobe_n <= 1'h1;
    w5;
endtask
task lat;
    latchStrobe_n <= 1'h0;
    w5;
    latchStrobe_n <= 1'h1;
    w5;
    w5;
endtask
endmodule // xpc_host

// File: dv/xpc_control_port_tb.sv
// Purpose: port bench; Assumes: host model; Notes: edge and level latch
`timescale 1ns/10ps
module xpc_control_port_tb;
reg core_clk = 1'h0;
reg rst_n = 1'h0;
reg edgeLatchSelect = 1'h1;
wire interfaceModeSelect, writeStrobe_n, latchStrobe_n, serialDataOut;
wire chipEnable, chipEnable_n;
wire [2:0] outputBufferSelect;
wire [3:0] routingCodeLinesIn;
wire [31:0] routeState;
wire [7:0] bufferEnable;
integer n_errors = 0;
integer num_checks = 0;
always #5 core_clk = ~core_clk;
xpc_host host_u (.*);
xpc_control_port dut_u (.*);
task chk(input [31:0] got, input [31:0] exp);
    num_checks = num_checks + 1;
    if (got !== exp)
    begin
        n_errors = n_errors + 1;
        $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
    end
endtask
task final_report;
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
        $display("All tests passed");
    else
        $display("Some tests failed");
    $finish;
endtask
task t_par;
    chk(bufferEnable, 32'h0);
    host_u.wr(3'h0, 4'h3);
    host_u.wr(3'h7, 4'h5);
    chk(routeState, 32'h0);
    host_u.lat;
    chk(routeState, 32'h50000003);
    $display("par end");
endtask
task t_ctl;
    host_u.wr(3'h2, 4'he);
    chk(bufferEnable, 32'hff);
    host_u.wr(3'h2, 4'hb);
    host_u.wr(3'h2, 4'h9);
    chk(bufferEnable, 32'hfb);
    host_u.chipEnable <= 1'h0;
    host_u.wr(3'h2, 4'hc);
    chk(bufferEnable, 32'hfb);
    host_u.chipEnable <= 1'h1;
    host_u.wr(3'h1, 4'h8);
    host_u.wr(3'h0, 4'hf);
    chk(routeState, 32'h50000083);
    $display("ctl end");
endtask
task t_lvl;
    edgeLatchSelect <= 1'h0;
    host_u.wr(3'h4, 4'h2);
    chk(routeState, 32'h50000083);
    host_u.latchStrobe_n <= 1'h0;
    host_u.w5;
    chk(routeState, 32'h50020083);
    host_u.wr(3'h5, 4'h1);
    chk(routeState, 32'h50120083);
    host_u.latchStrobe_n <= 1'h1;
    host_u.w5;
    edgeLatchSelect <= 1'h1;
    host_u.w5;
    $display("lvl end");
endtask
task t_ser(input [31:0] w, input [31:0] r);
    host_u.interfaceModeSelect <= 1'h1;
    for (int i = 0; i < 32; i++)
        host_u.wr(3'h0, {3'h0, w[i]});
    chk(serialDataOut, w[0]);
    host_u.lat;
    chk(routeState, r);
    chk(bufferEnable, 32'hfe);
    $display("ser end");
endtask
initial
begin
    repeat (16) @(posedge core_clk);
    rst_n <= 1'h1;
    repeat (4) @(posedge core_clk);
    t_par;
    t_ctl;
    t_lvl;
    t_ser(32'h0123496a, 32'h0123496a);
    t_ser(32'h0000000f, 32'h0123496a);
    final_report;
end
initial
begin
    #50000;
    n_errors = n_errors + 1;
    final_report;
end
endmodule // xpc_control_port_tb
